// ---- verilog/sbs_pkg.sv ----
package sbs_pkg;

	// Register byte addresses (word aligned)
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_TXDATA = 4'h8;
	localparam logic [3:0] ADDR_RXDATA = 4'hc;

	// Control register field positions
	localparam int CTRL_PORT_EN   = 0;
	localparam int CTRL_SYNC      = 1;
	localparam int CTRL_CLK_MSTR  = 2;
	localparam int CTRL_TX_EN     = 3;
	localparam int CTRL_SEND_BRK  = 4;
	localparam int CTRL_SINGLE_RX_ENABLE      = 5;
	localparam int CTRL_CONTINUOUS_RX_ENABLE      = 6;
	localparam int CTRL_CLK_POL   = 7;
	localparam int CTRL_WAKE_EN   = 8;
	localparam int CTRL_BAUD_LSB  = 16;

	// Status register field positions
	localparam int STAT_TX_IRQ    = 0;
	localparam int STAT_SHIFT_MT  = 1;
	localparam int STAT_RX_IRQ    = 2;
	localparam int STAT_FRAME_ERR = 3;
	localparam int STAT_RX_IDLE   = 4;

	localparam logic [15:0] BAUD_DIV_RST = 16'h000f;
	localparam logic [3:0]  BRK_ZEROS    = 4'hc;
	localparam logic [3:0]  DATA_BITS    = 4'h8;
	localparam logic [7:0]  BRK_RX_VALUE = 8'h00;

	typedef struct packed {
		logic        wake_on_break_en;
		logic        clock_polarity_bit;
		logic        continuous_rx_enable;
		logic        single_rx_enable;
		logic        send_break_bit;
		logic        tx_enable_bit;
		logic        clock_source_master;
		logic        sync_mode;
		logic        port_enable;
	} ctrl_type;

	typedef struct packed {
		logic [7:0]  data;
		logic        is_break;
	} tx_char_type;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_BITS  = 3'b010,
		TX_STOP  = 3'b011,
		TX_SLOW  = 3'b100,
		TX_SHIGH = 3'b101
	} tx_state_type;

endpackage : sbs_pkg

// ---- verilog/serial_break_sync_master.sv ----
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Wake event while wake-on-break armed sets the receive interrupt flag.
// - Rising edge on data line clears wake-on-break enable in hardware.
// - Reading receive data register clears the wake interrupt; value is discarded.
// - Break is start bit, twelve zero bits, one stop bit.
// - Break starts on transmit-data write with send-break and transmit-enable set.
// - During a break the written value is ignored; only zeros go out.
// - Send-break clears after the break stop bit; preloaded byte follows.
// - Shift-empty status tracks break transmission like ordinary characters.
// - Transmit flag shows data register empty; write only then.
// - Received break shows receive flag, framing error and data 00h.
// - With wake armed, one falling edge raises an interrupt, next byte another.
// - Sync mode: one data line, one clock line, half duplex, no framing.
// - Sync master needs sync, clock source, port enable; sync transmit needs both rx enables clear.
// - Sync master drives shift clock and enables clock pin driver.
// - Exactly one clock cycle per data bit, none extra.
// - Data changes on leading edge, valid at trailing edge.
// - Polarity set idles clock high; clear idles low.
// - Sync master transmit enables both data and clock drivers.
// - Written char waits until shift register empties, else moves at once.
module serial_break_sync_master
	import sbs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rx_data_pin_in,
	output logic             rx_data_pin_out,
	output logic             rx_data_pin_oe,
	output logic             tx_clock_pin_out,
	output logic             tx_clock_pin_oe
);

	ctrl_type     ctrl_ff;
	logic [15:0]  baud_div_ff;
	tx_char_type  hold_ff;
	logic         hold_full_ff;
	logic [7:0]   shift_ff;
	logic         shift_brk_ff;
	logic [3:0]   bit_cnt_ff;
	tx_state_type state_ff;
	logic [15:0]  baud_cnt_ff;
	logic         line_ff;
	logic         clk_pin_ff;
	logic         tx_irq_flag_ff;
	logic         rx_irq_flag_ff;
	logic         framing_error_ff;
	logic [7:0]   rx_data_reg_ff;
	logic         rx_meta_ff;
	logic         rx_sync_ff;
	logic         rx_prev_ff;
	logic         ack_ff;
	logic         wake_fell_ff;

	// Programmable baud divider; ordinary characters are also received here,
	// so this block sees the line for character, break and wake detection.
	logic baud_tick;
	logic sync_master;
	logic sync_tx;
	logic do_load;
	logic wr_tx;
	logic rd_rx;
	logic wr_ctrl;
	logic rx_rise;
	logic rx_fall;
	logic brk_done;
	logic low_run_ff;
	logic [4:0] low_bits_ff;
	logic         rx_on;
	logic         rx_sample;
	logic         rx_done;
	logic         rx_busy_ff;
	logic [3:0]   rx_idx_ff;
	logic [7:0]   rx_shift_ff;
	logic [15:0]  rx_cnt_ff;

	assign baud_tick   = (baud_cnt_ff == 16'h0000);
	assign sync_master = ctrl_ff.sync_mode && ctrl_ff.clock_source_master
	                     && ctrl_ff.port_enable;
	assign sync_tx     = sync_master && !ctrl_ff.single_rx_enable
	                     && !ctrl_ff.continuous_rx_enable;
	assign rx_rise     = rx_sync_ff && !rx_prev_ff;
	assign rx_fall     = !rx_sync_ff && rx_prev_ff;

	// Bus: one wait cycle per access, answered on the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
	assign wr_tx   = avs_write && ack_ff && (avs_address == ADDR_TXDATA);
	assign wr_ctrl = avs_write && ack_ff && (avs_address == ADDR_CTRL);
	assign rd_rx   = avs_read && ack_ff && (avs_address == ADDR_RXDATA);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read || avs_write) && !ack_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if ((avs_read) && !ack_ff) begin
			case (avs_address)
				ADDR_CTRL: begin
					avs_readdata <= {baud_div_ff, 7'h00, ctrl_ff};
				end
				ADDR_STATUS: begin
					avs_readdata <= {27'h0000000, !rx_busy_ff && !wake_fell_ff,
						framing_error_ff, rx_irq_flag_ff, (state_ff == TX_IDLE),
						tx_irq_flag_ff};
				end
				ADDR_RXDATA: begin
					avs_readdata <= {24'h000000, rx_data_reg_ff};
				end
				default: begin
					avs_readdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Input synchroniser for the data line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_meta_ff <= rx_data_pin_in;
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_cnt_ff <= BAUD_DIV_RST;
		end else if (baud_tick || wr_ctrl || do_load) begin
			baud_cnt_ff <= baud_div_ff;
		end else begin
			baud_cnt_ff <= baud_cnt_ff - 16'h0001;
		end
	end

	// Control register; hardware clears of send-break and wake win over writes
	assign brk_done = (state_ff == TX_STOP) && baud_tick && shift_brk_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff     <= '0;
			baud_div_ff <= BAUD_DIV_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff     <= ctrl_type'(avs_writedata[8:0]);
				baud_div_ff <= avs_writedata[31:16];
			end
			if (brk_done) begin
				ctrl_ff.send_break_bit <= 1'b0;
			end
			if (ctrl_ff.wake_on_break_en && wake_fell_ff && rx_rise) begin
				ctrl_ff.wake_on_break_en <= 1'b0;
			end
		end
	end

	// Holding register: a char waits here until the shifter takes it
	assign do_load = hold_full_ff && (state_ff == TX_IDLE) && ctrl_ff.tx_enable_bit;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff      <= '0;
			hold_full_ff <= 1'b0;
		end else if (wr_tx) begin
			hold_ff.data     <= avs_writedata[7:0];
			hold_ff.is_break <= ctrl_ff.send_break_bit && ctrl_ff.tx_enable_bit
			                    && !ctrl_ff.sync_mode
			                    && !(shift_brk_ff && state_ff != TX_IDLE);
			hold_full_ff     <= 1'b1;
		end else if (do_load) begin
			hold_full_ff <= 1'b0;
		end
	end

	// Transmit flag: set on transfer to shifter; a write clears it, set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_irq_flag_ff <= 1'b1;
		end else if (do_load) begin
			tx_irq_flag_ff <= 1'b1;
		end else if (wr_tx) begin
			tx_irq_flag_ff <= 1'b0;
		end
	end

	// Shifter: async frames use baud ticks; sync master uses two ticks per bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff     <= TX_IDLE;
			shift_ff     <= 8'h00;
			shift_brk_ff <= 1'b0;
			bit_cnt_ff   <= 4'h0;
			line_ff      <= 1'b1;
			clk_pin_ff   <= 1'b0;
		end else begin
			case (state_ff)
				TX_IDLE: begin
					clk_pin_ff <= ctrl_ff.clock_polarity_bit;
					if (do_load) begin
						shift_ff     <= hold_ff.is_break ? 8'h00 : hold_ff.data;
						shift_brk_ff <= hold_ff.is_break;
						bit_cnt_ff   <= hold_ff.is_break ? BRK_ZEROS : DATA_BITS;
						if (sync_tx) begin
							state_ff <= TX_SLOW;
						end else begin
							state_ff <= TX_START;
						end
					end
				end
				TX_START: begin
					line_ff <= 1'b0;
					if (baud_tick) begin
						state_ff <= TX_BITS;
					end
				end
				TX_BITS: begin
					line_ff <= shift_ff[0];
					if (baud_tick) begin
						shift_ff   <= {1'b0, shift_ff[7:1]};
						bit_cnt_ff <= bit_cnt_ff - 4'h1;
						if (bit_cnt_ff == 4'h1) begin
							state_ff <= TX_STOP;
						end
					end
				end
				TX_STOP: begin
					line_ff <= 1'b1;
					if (baud_tick) begin
						state_ff <= TX_IDLE;
					end
				end
				TX_SLOW: begin
					// Leading edge moves the data, so it holds through the trailing edge
					if (baud_tick) begin
						clk_pin_ff <= !ctrl_ff.clock_polarity_bit;
						line_ff    <= shift_ff[0];
						state_ff   <= TX_SHIGH;
					end
				end
				TX_SHIGH: begin
					if (baud_tick) begin
						clk_pin_ff <= ctrl_ff.clock_polarity_bit;
						shift_ff   <= {1'b0, shift_ff[7:1]};
						bit_cnt_ff <= bit_cnt_ff - 4'h1;
						state_ff   <= (bit_cnt_ff == 4'h1) ? TX_IDLE : TX_SLOW;
					end
				end
				default: begin
					state_ff <= TX_IDLE;
				end
			endcase
		end
	end

	// Pin drivers
	assign rx_data_pin_out  = line_ff;
	assign rx_data_pin_oe   = sync_tx && ctrl_ff.tx_enable_bit;
	assign tx_clock_pin_out = sync_master ? clk_pin_ff : line_ff;
	assign tx_clock_pin_oe  = ctrl_ff.port_enable &&
	                          (sync_master || !ctrl_ff.sync_mode);

	// Wake-on-break: falling edge is the wake event, rising edge ends break
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_fell_ff <= 1'b0;
		end else if (!ctrl_ff.wake_on_break_en) begin
			wake_fell_ff <= 1'b0;
		end else if (rx_fall) begin
			wake_fell_ff <= 1'b1;
		end
	end

	// Break length detector on the line, for received-break reporting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_run_ff  <= 1'b0;
			low_bits_ff <= 5'h00;
		end else if (rx_sync_ff || ctrl_ff.sync_mode) begin
			low_run_ff  <= 1'b0;
			low_bits_ff <= 5'h00;
		end else if (baud_tick && low_bits_ff != 5'h1f) begin
			low_run_ff  <= 1'b1;
			low_bits_ff <= low_bits_ff + 5'h01;
		end
	end

	// Character receiver: samples mid-bit; idle while wake-on-break owns the line
	assign rx_on     = ctrl_ff.port_enable && !ctrl_ff.sync_mode
	                   && ctrl_ff.continuous_rx_enable && !ctrl_ff.wake_on_break_en;
	assign rx_sample = rx_busy_ff && (rx_cnt_ff == 16'h0000);
	assign rx_done   = rx_sample && (rx_idx_ff == DATA_BITS + 4'h1);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy_ff  <= 1'b0;
			rx_idx_ff   <= 4'h0;
			rx_shift_ff <= 8'h00;
			rx_cnt_ff   <= 16'h0000;
		end else if (!rx_on) begin
			rx_busy_ff <= 1'b0;
		end else if (!rx_busy_ff) begin
			rx_busy_ff <= rx_fall;
			rx_idx_ff  <= 4'h0;
			rx_cnt_ff  <= {1'b0, baud_div_ff[15:1]};
		end else if (rx_sample) begin
			// A start bit that is high again at its centre was a glitch
			rx_busy_ff  <= !(rx_done || (rx_idx_ff == 4'h0 && rx_sync_ff));
			rx_idx_ff   <= rx_idx_ff + 4'h1;
			rx_cnt_ff   <= baud_div_ff;
			rx_shift_ff <= rx_done ? rx_shift_ff : {rx_sync_ff, rx_shift_ff[7:1]};
		end else begin
			rx_cnt_ff <= rx_cnt_ff - 16'h0001;
		end
	end

	// Receive flag: wake event, long low or received char; read of data clears, set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_irq_flag_ff   <= 1'b0;
			framing_error_ff <= 1'b0;
			rx_data_reg_ff   <= 8'h00;
		end else if (ctrl_ff.wake_on_break_en && rx_fall && !wake_fell_ff) begin
			rx_irq_flag_ff <= 1'b1;
		end else if (!ctrl_ff.wake_on_break_en && low_run_ff && rx_rise
		             && low_bits_ff >= {1'b0, DATA_BITS} + 5'h02) begin
			rx_irq_flag_ff   <= 1'b1;
			framing_error_ff <= 1'b1;
			rx_data_reg_ff   <= BRK_RX_VALUE;
		end else if (rx_done) begin
			rx_irq_flag_ff   <= 1'b1;
			framing_error_ff <= !rx_sync_ff;
			rx_data_reg_ff   <= rx_shift_ff;
		end else if (rd_rx) begin
			rx_irq_flag_ff   <= 1'b0;
			framing_error_ff <= 1'b0;
		end
	end

	AST_BRK_ZEROS: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == TX_BITS && shift_brk_ff) |-> !line_ff || $past(state_ff) != TX_BITS)
		else $error("break sent a one bit");
	AST_BRK_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		brk_done |=> !ctrl_ff.send_break_bit) else $error("send break not cleared");
	AST_BRK_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		(do_load && hold_ff.is_break) |=> bit_cnt_ff == BRK_ZEROS) else $error("break length");
	AST_TX_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		do_load |=> tx_irq_flag_ff && !hold_full_ff) else $error("tx flag not set on load");
	AST_WAKE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_ff.wake_on_break_en && wake_fell_ff && rx_rise) |=> !ctrl_ff.wake_on_break_en)
		else $error("wake enable not cleared");
	AST_WAKE_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_ff.wake_on_break_en && rx_fall && !wake_fell_ff) |=> rx_irq_flag_ff)
		else $error("wake irq missing");
	AST_CLK_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		(sync_master && state_ff == TX_IDLE && $past(state_ff) == TX_IDLE)
		|-> clk_pin_ff == $past(ctrl_ff.clock_polarity_bit)) else $error("clock idle level");
	AST_DATA_OE: assert property (@(posedge clk) disable iff (!rst_n)
		(sync_tx && ctrl_ff.tx_enable_bit) |-> rx_data_pin_oe && tx_clock_pin_oe)
		else $error("sync tx drivers off");
	AST_DATA_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == TX_SHIGH |=> $stable(line_ff)) else $error("data moved");
	AST_RD_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_rx && !rx_fall && !rx_rise && !rx_done) |=> !rx_irq_flag_ff)
		else $error("read no clear");
	AST_RX_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
		rx_done |=> rx_irq_flag_ff && rx_data_reg_ff == $past(rx_shift_ff))
		else $error("received byte not posted");

	COV_BREAK: cover property (@(posedge clk) disable iff (!rst_n) brk_done);
	COV_SYNC_TX: cover property (@(posedge clk) disable iff (!rst_n)
		state_ff == TX_SHIGH ##1 state_ff == TX_IDLE);
	COV_WAKE: cover property (@(posedge clk) disable iff (!rst_n)
		ctrl_ff.wake_on_break_en ##1 !ctrl_ff.wake_on_break_en);
	COV_RX_BRK: cover property (@(posedge clk) disable iff (!rst_n) framing_error_ff);

endmodule : serial_break_sync_master

`default_nettype wire

// ---- tb/remote_node.sv ----
`timescale 1ns/10ps
`default_nettype none

module remote_node #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic clk,
	input  wire logic clock_pol,
	input  wire logic dut_ck,
	input  wire logic dut_dat,
	input  wire logic dut_dat_oe,
	output logic      line_level
);
	logic       drive_en  = 1'b0;
	logic       drive_val = 1'b1;
	logic       ck_q      = 1'b0;
	logic [7:0] sync_byte = 8'h00;
	int         sync_clks = 0;

	// Device wins while it drives; a line nobody drives floats to its pull-up
	assign line_level = dut_dat_oe ? dut_dat : (drive_en ? drive_val : 1'b1);

	// Slave takes each bit on the trailing edge, the return to idle level
	always @(posedge clk) begin
		ck_q <= dut_ck;
		if (ck_q !== clock_pol && dut_ck === clock_pol) begin
			sync_byte <= {line_level, sync_byte[7:1]};
			sync_clks <= sync_clks + 1;
		end
	end

	task set_line(input logic v);
		drive_en  <= 1'b1;
		drive_val <= v;
	endtask : set_line

	task hold_bits(input int n);
		repeat (n * BIT_CLKS) @(posedge clk);
	endtask : hold_bits

	task send_byte(input logic [7:0] b);
		set_line(1'b0);
		hold_bits(1);
		for (int i = 0; i < 8; i++) begin
			set_line(b[i]);
			hold_bits(1);
		end
		set_line(1'b1);
		hold_bits(1);
		drive_en <= 1'b0;
	endtask : send_byte

	task clear_sync();
		sync_clks <= 0;
		sync_byte <= 8'h00;
	endtask : clear_sync
endmodule : remote_node

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import sbs_pkg::*;
;
	localparam int          BITC = 32;
	localparam logic [31:0] CB   = 32'h001f0000;

	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  a;
	logic        rd_s;
	logic        wr_s;
	logic [31:0] wd;
	logic [31:0] rdata;
	logic        wreq;
	logic        rxi;
	logic        rxo;
	logic        rxoe;
	logic        cko;
	logic        ckoe;
	logic        pol_v;
	logic [31:0] rq;
	logic [15:0] capb;
	int          fail_count = 0;
	int          compares   = 0;

	always #2.5 clk = ~clk;

	serial_break_sync_master dut_u (
		.clk(clk), .rst_n(rst_n), .avs_address(a), .avs_read(rd_s), .avs_write(wr_s),
		.avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.rx_data_pin_in(rxi), .rx_data_pin_out(rxo), .rx_data_pin_oe(rxoe),
		.tx_clock_pin_out(cko), .tx_clock_pin_oe(ckoe)
	);

	remote_node #(.BIT_CLKS(BITC)) node (
		.clk(clk), .clock_pol(pol_v), .dut_ck(cko), .dut_dat(rxo),
		.dut_dat_oe(rxoe), .line_level(rxi)
	);

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task final_report();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	// Request held until waitrequest is seen low at a rising edge
	task bus(input logic [3:0] adr, input logic w, input logic [31:0] d);
		@(posedge clk);
		a    <= adr;
		wr_s <= w;
		rd_s <= !w;
		wd   <= d;
		@(posedge clk);
		while (wreq !== 1'b0) @(posedge clk);
		rq = rdata;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask : bus

	// Samples n async bits at their centres from the first falling edge
	task cap(input int n);
		capb = '0;
		while (cko !== 1'b0) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (i == 0 ? BITC / 2 : BITC) @(posedge clk);
			capb[i] = cko;
		end
	endtask : cap

	task wait_sync(input int n);
		int k;
		k = 0;
		while (node.sync_clks < n && k < 4000) begin
			@(posedge clk);
			k++;
		end
	endtask : wait_sync

	task t_reset();
		bus(ADDR_CTRL, 1'b0, 32'h0);
		chk("ctrl_rst", rq, 32'h000f0000);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("stat_rst", rq & 32'h0f, 32'h03);
		bus(4'h2, 1'b1, 32'hffff_ffff);
		bus(4'h2, 1'b0, 32'h0);
		chk("unmapped", rq, 32'h0);
	endtask : t_reset

	task t_break();
		bus(ADDR_CTRL, 1'b1, CB | 32'h19);
		fork
			cap(14);
			begin
				bus(ADDR_TXDATA, 1'b1, 32'hff);
				bus(ADDR_STATUS, 1'b0, 32'h0);
				chk("brk_busy", rq & 32'h3, 32'h1);
				bus(ADDR_TXDATA, 1'b1, 32'h55);
				bus(ADDR_STATUS, 1'b0, 32'h0);
				chk("sync_held", rq & 32'h1, 32'h0);
			end
		join
		chk("brk_bits", 32'(capb[13:0]), 32'h2000);
		cap(10);
		chk("sync_char", 32'(capb[9:0]), 32'h2aa);
		repeat (2 * BITC) @(posedge clk);
		bus(ADDR_CTRL, 1'b0, 32'h0);
		chk("brk_clr", rq, CB | 32'h09);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("tx_idle", rq & 32'h3, 32'h3);
	endtask : t_break

	task t_rx_break();
		bus(ADDR_CTRL, 1'b1, CB | 32'h41);
		node.set_line(1'b0);
		node.hold_bits(11);
		node.set_line(1'b1);
		node.hold_bits(2);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("brk_flags", rq & 32'hc, 32'hc);
		bus(ADDR_RXDATA, 1'b0, 32'h0);
		chk("brk_data", rq & 32'hff, 32'h00);
	endtask : t_rx_break

	task t_wake();
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("rx_idle", rq & 32'h1c, 32'h10);
		bus(ADDR_CTRL, 1'b1, CB | 32'h141);
		node.set_line(1'b0);
		node.hold_bits(2);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("wake_irq", rq & 32'h4, 32'h4);
		bus(ADDR_RXDATA, 1'b0, 32'h0);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("wake_ack", rq & 32'h4, 32'h0);
		bus(ADDR_CTRL, 1'b0, 32'h0);
		chk("wake_armed", rq, CB | 32'h141);
		node.hold_bits(11);
		node.set_line(1'b1);
		node.hold_bits(2);
		bus(ADDR_CTRL, 1'b0, 32'h0);
		chk("wake_clr", rq, CB | 32'h41);
		node.send_byte(8'ha5);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("byte_irq", rq & 32'h4, 32'h4);
		bus(ADDR_RXDATA, 1'b0, 32'h0);
		chk("byte_data", rq & 32'hff, 32'ha5);
	endtask : t_wake

	task t_sync(input logic p);
		pol_v <= p;
		bus(ADDR_CTRL, 1'b1, CB | 32'h0f | (32'(p) << CTRL_CLK_POL));
		repeat (8) @(posedge clk);
		node.clear_sync();
		chk("ck_idle", 32'(cko), 32'(p));
		chk("ck_oe", 32'(ckoe), 32'h1);
		bus(ADDR_TXDATA, 1'b1, 32'ha6);
		bus(ADDR_TXDATA, 1'b1, 32'h3c);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("sync_held", rq & 32'h3, 32'h0);
		wait_sync(8);
		chk("dat_oe", 32'(rxoe), 32'h1);
		chk("sync_b0", 32'(node.sync_byte), 32'ha6);
		wait_sync(16);
		chk("sync_b1", 32'(node.sync_byte), 32'h3c);
		repeat (200) @(posedge clk);
		chk("sync_clks", 32'(node.sync_clks), 32'd16);
		chk("ck_rest", 32'(cko), 32'(p));
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("sync_done", rq & 32'h3, 32'h3);
	endtask : t_sync

	// Whole run is some 5k cycles; the limit leaves wide margin
	initial begin
		#200000;
		fail_count++;
		final_report();
	end

	initial begin
		a     <= 4'h0;
		rd_s  <= 1'b0;
		wr_s  <= 1'b0;
		wd    <= 32'h0;
		pol_v <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_break();
		t_rx_break();
		t_wake();
		t_sync(1'b0);
		t_sync(1'b1);
		final_report();
	end
endmodule : tb_top

`default_nettype wire
